// [logic/pbs_pkg.sv]
// constants, carriers and helpers of the pipelined burst memory port
// assumes one clock; host logic drives the port on the same clock
// Operation
// - 512K words of 36 bits, 9-bit bytes
// - data transfer two cycles after the load
// - reads and writes back to back, no idle
// - clock hold freezes port registers, ignores inputs; queued writes still drain to the array
// - held edge leaves outputs as if absent
// - load without all selects is a deselect
// - bus floats two cycles after deselect/write
// - four data beats from one address
// - low loads address, high steps counter
// - deselect with load ends running burst
// - enabled bytes stored, ignored on reads
// - order input high interleaved, low linear
// - output disable floats data pins asynchronously
// - write data and read data are registered
// - selected: two low selects, one high
// - sleep gates the clock, keeps data
package pbs_pkg;

  localparam int BYTE_W    = 9;
  localparam int NBYTE     = 4;
  localparam int WORD_W    = BYTE_W * NBYTE;
  localparam int ADDR_W    = 19;
  localparam int MEM_WORDS = 1 << ADDR_W;
  localparam int FIFO_DEPTH = 16;
  localparam int BURST_LO_W = 2;

  localparam logic [BURST_LO_W-1:0] CNT_RST  = 2'h0;
  localparam logic [BURST_LO_W-1:0] CNT_STEP = 2'h1;
  localparam logic [WORD_W-1:0]     WORD_RST = 36'h0;
  localparam logic [NBYTE-1:0]      BE_OFF_N = 4'hf;

  typedef logic [ADDR_W-1:0] pbs_addr_t;
  typedef logic [WORD_W-1:0] pbs_word_t;

  typedef struct packed {
    logic             valid;
    logic             write;
    pbs_addr_t        addr;
    logic [NBYTE-1:0] be_n;
  } pbs_cmd_t;

  typedef struct packed {
    pbs_addr_t        addr;
    pbs_word_t        data;
    logic [NBYTE-1:0] be;
  } pbs_wr_t;

  typedef struct packed {
    pbs_cmd_t                s1;
    logic                    burst_on;
    logic [BURST_LO_W-1:0]   base;
    logic [BURST_LO_W-1:0]   cnt;
    pbs_cmd_t                s2;
    pbs_word_t               rdata;
    logic                    drive;
    pbs_wr_t                 wcap;
    logic                    wvalid;
  } pbs_state_t;

  localparam pbs_cmd_t CMD_RST = '{valid: 1'b0, write: 1'b0,
                                   addr: '0, be_n: BE_OFF_N};

  // low address bits of a burst beat
  function automatic logic [BURST_LO_W-1:0] pbs_burst_lo(
    input logic [BURST_LO_W-1:0] base,
    input logic [BURST_LO_W-1:0] cnt,
    input logic                  ilv);
    pbs_burst_lo = ilv ? (base ^ cnt) : (base + cnt);
  endfunction

  // overlay enabled bytes of nw onto old
  function automatic pbs_word_t pbs_merge(
    input pbs_word_t        old,
    input pbs_word_t        nw,
    input logic [NBYTE-1:0] be);
    pbs_merge = old;
    for (int b = 0; b < NBYTE; b++) begin
      if (be[b]) begin
        pbs_merge[b*BYTE_W +: BYTE_W] = nw[b*BYTE_W +: BYTE_W];
      end
    end
  endfunction

endpackage

// [logic/pbs_fifo.sv]
// flip-flop fifo with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
module pbs_fifo
  import pbs_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             ref_clk_i,  // clock
  input  wire logic             arst_n_i,   // async reset, low
  input  wire logic             in_valid_i, // push request
  output logic                  in_ready_o, // not full
  input  wire logic [WIDTH-1:0] in_data_i,  // push word
  output logic                  out_valid_o,// not empty
  input  wire logic             out_ready_i,// pop request
  output logic [WIDTH-1:0]      out_data_o  // head word
);

  localparam int PW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin
      $error("pbs_fifo: depth must be a power of two >= 2");
    end
  end

  typedef struct packed {
    logic [PW-1:0] rd;
    logic [PW-1:0] wr;
    logic [PW:0]   cnt;
  } pbs_fifo_st_t;

  pbs_fifo_st_t     st;
  pbs_fifo_st_t     next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready_o  = (st.cnt != (PW+1)'(DEPTH));
  assign out_valid_o = (st.cnt != '0);
  assign out_data_o  = mem[st.rd];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr = st.wr + PW'(1);
    end
    if (pop) begin
      next_st.rd = st.rd + PW'(1);
    end
    next_st.cnt = st.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[st.wr] <= in_data_i;
    end
  end

endmodule

// [logic/pbs_port.sv]
// pipelined burst static memory port: registered address/control,
// data two cycles later, 4-beat burst counter, per-byte writes
// assumes host logic on ref_clk_i drives all synchronous inputs
`timescale 1ns/1ps
module pbs_port
  import pbs_pkg::*;
#(
  parameter int WFIFO_DEPTH = FIFO_DEPTH
) (
  input  wire logic              ref_clk_i,            // clock, 40 MHz
  input  wire logic              arst_n_i,             // async reset, low
  input  wire logic [ADDR_W-1:0] address_in_i,         // word address
  input  wire logic              advance_or_load_i,    // 0 load, 1 step
  input  wire logic              read_write_i,         // 1 read, 0 write
  input  wire logic              clock_hold_n_i,       // 1 suspends
  input  wire logic [NBYTE-1:0]  byte_write_n_i,       // byte enables, low
  input  wire logic              chip_select_a_n_i,    // select, low
  input  wire logic              chip_select_high_i,   // select, high
  input  wire logic              chip_select_b_n_i,    // select, low
  input  wire logic              burst_order_select_i, // 1 interleaved
  input  wire logic              output_disable_i,     // 1 floats bus
  input  wire logic              sleep_request_i,      // 1 sleep
  input  wire logic [WORD_W-1:0] data_bus_i,           // bus level
  output logic [WORD_W-1:0]      data_bus_o,           // read data
  output logic                   data_bus_oe_o         // drives bus
);

  initial begin
    if (WFIFO_DEPTH < 2) begin
      $error("pbs_port: write fifo depth below 2");
    end
  end

  pbs_state_t st;
  pbs_state_t next_st;
  pbs_word_t  mem [MEM_WORDS];
  pbs_word_t  rd_word;
  logic       selected;
  logic       hold;
  logic       stall;
  logic       f_in_valid;
  logic       f_in_ready;
  logic       f_out_valid;
  logic       f_out_ready;
  pbs_wr_t    f_head;
  logic       load_op;
  logic       desel_op;

  assign selected = ~chip_select_a_n_i & chip_select_high_i
                  & ~chip_select_b_n_i;
  assign hold     = clock_hold_n_i | sleep_request_i;
  assign stall    = hold | (st.wvalid & ~f_in_ready);
  assign load_op  = ~advance_or_load_i & selected;
  assign desel_op = ~advance_or_load_i & ~selected;

  // committed writes queue here until the array takes them
  assign f_in_valid  = st.wvalid & ~hold;
  assign f_out_ready = ~sleep_request_i;

  pbs_fifo #(
    .WIDTH ($bits(pbs_wr_t)),
    .DEPTH (WFIFO_DEPTH)
  ) u_wfifo (
    .ref_clk_i   (ref_clk_i),
    .arst_n_i    (arst_n_i),
    .in_valid_i  (f_in_valid),
    .in_ready_o  (f_in_ready),
    .in_data_i   (st.wcap),
    .out_valid_o (f_out_valid),
    .out_ready_i (f_out_ready),
    .out_data_o  (f_head)
  );

  // array read with bypass of writes not yet in the array
  always_comb begin
    rd_word = mem[st.s2.addr];
    if (f_out_valid && f_head.addr == st.s2.addr) begin
      rd_word = pbs_merge(rd_word, f_head.data, f_head.be);
    end
    if (st.wvalid && st.wcap.addr == st.s2.addr) begin
      rd_word = pbs_merge(rd_word, st.wcap.data, st.wcap.be);
    end
  end

  always_comb begin
    next_st = st;
    if (f_in_valid && f_in_ready) begin
      next_st.wvalid = 1'b0;
    end
    if (!stall) begin
      if (!advance_or_load_i) begin
        if (selected) begin
          next_st.s1.valid = 1'b1;
          next_st.s1.write = ~read_write_i;
          next_st.s1.addr  = address_in_i;
          next_st.s1.be_n  = read_write_i ? BE_OFF_N
                                          : byte_write_n_i;
          next_st.burst_on = 1'b1;
          next_st.base     = address_in_i[BURST_LO_W-1:0];
          next_st.cnt      = CNT_RST;
        end else begin
          next_st.s1       = CMD_RST;
          next_st.burst_on = 1'b0;
        end
      end else if (st.burst_on) begin
        next_st.cnt      = st.cnt + CNT_STEP;
        next_st.s1.valid = 1'b1;
        next_st.s1.addr[BURST_LO_W-1:0] =
          pbs_burst_lo(st.base, st.cnt + CNT_STEP,
                       burst_order_select_i);
        next_st.s1.be_n  = st.s1.write ? byte_write_n_i
                                       : BE_OFF_N;
      end else begin
        next_st.s1 = CMD_RST;
      end
      next_st.s2    = st.s1;
      next_st.drive = 1'b0;
      if (st.s2.valid && !st.s2.write) begin
        next_st.rdata = rd_word;
        next_st.drive = 1'b1;
      end
      if (st.s2.valid && st.s2.write) begin
        next_st.wcap.addr = st.s2.addr;
        next_st.wcap.data = data_bus_i;
        next_st.wcap.be   = ~st.s2.be_n;
        next_st.wvalid    = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '{s1: CMD_RST, burst_on: 1'b0, base: CNT_RST,
              cnt: CNT_RST, s2: CMD_RST, rdata: WORD_RST,
              drive: 1'b0, wcap: '0, wvalid: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // array is not reset so stored data survives everything
  always_ff @(posedge ref_clk_i) begin
    if (f_out_valid && f_out_ready) begin
      mem[f_head.addr] <= pbs_merge(mem[f_head.addr], f_head.data,
                                    f_head.be);
    end
  end

  assign data_bus_o    = st.rdata;
  assign data_bus_oe_o = st.drive & ~output_disable_i
                       & ~sleep_request_i;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  logic ld_rd;
  logic ld_wr;
  assign ld_rd = load_op & read_write_i;
  assign ld_wr = load_op & ~read_write_i;

  chk_read_latency: assert property (
    (ld_rd && !stall) ##1 !stall ##1 !stall |=> st.drive)
    else $error("read data not driven two cycles after load");

  chk_hold_freeze: assert property (
    clock_hold_n_i |=> $stable(st))
    else $error("state changed during clock hold");

  chk_hold_outputs: assert property (
    (clock_hold_n_i && !sleep_request_i && !output_disable_i)
    ##1 (!sleep_request_i && !output_disable_i)
    |-> $stable(data_bus_o) && $stable(data_bus_oe_o))
    else $error("outputs moved on a held edge");

  chk_deselect_idle: assert property (
    (desel_op && !stall) |=> !st.s1.valid)
    else $error("deselect started an operation");

  chk_float_after: assert property (
    ((desel_op || ld_wr) && !stall) ##1 !stall ##1 !stall
    |=> !data_bus_oe_o)
    else $error("bus driven after deselect or write");

  chk_burst_wrap: assert property (
    (load_op && !stall && !burst_order_select_i)
    ##1 (advance_or_load_i && !stall && !burst_order_select_i)
    |=> st.s1.valid
        && st.s1.addr[1:0] == 2'($past(address_in_i[1:0], 2) + 2'h1)
        && st.s1.addr[ADDR_W-1:2] == $past(address_in_i[ADDR_W-1:2], 2))
    else $error("linear burst step moved the wrong address bits");

  chk_burst_ends: assert property (
    (desel_op && !stall) ##1 (advance_or_load_i && !stall)
    |=> !st.s1.valid)
    else $error("burst continued after deselect");

  chk_read_no_be: assert property (
    (ld_rd && !stall) |=> st.s1.be_n == BE_OFF_N)
    else $error("byte enables kept on a read");

  chk_select_load: assert property (
    (load_op && !stall) |=> st.s1.valid && st.burst_on)
    else $error("selected load did not start an access");

  chk_oe_float: assert property (
    (output_disable_i || sleep_request_i) |-> !data_bus_oe_o)
    else $error("bus driven while disabled or asleep");

  cov_read: cover property (
    (ld_rd && !stall) ##2 data_bus_oe_o);
  cov_wr_rd: cover property (
    (ld_wr && !stall) ##1 (ld_rd && !stall));
  cov_burst: cover property (
    (load_op && !stall) ##1 (advance_or_load_i && !stall) [*3]);
  cov_hold: cover property (st.drive && clock_hold_n_i);

endmodule

// [tb/pbs_host.sv]
// host controller model: drives every port input except clock and reset, resolves the data bus
// assumes the bench calls cyc once per clock cycle
`timescale 1ns/1ps
module pbs_host
  import pbs_pkg::*;
(
  input  wire logic              ref_clk_i, // clock
  input  wire logic [WORD_W-1:0] rd_data_i, // port read data
  input  wire logic              rd_oe_i,   // port drives bus
  output pbs_addr_t              addr_o,    // word address
  output logic                   adv_o,     // 0 load, 1 step
  output logic                   rw_o,      // 1 read, 0 write
  output logic [1:0]             susp_o,    // {sleep, hold}
  output logic [NBYTE-1:0]       be_n_o,    // byte enables, low
  output logic [2:0]             sel_o,     // {a_n, high, b_n}
  output logic                   ilv_o,     // 1 interleaved
  output logic                   odis_o,    // 1 floats bus
  output logic [WORD_W-1:0]      bus_o      // resolved bus level
);
  pbs_word_t wd1, wd2, wv, last;
  logic      we1, we2, wen, wb;
  pbs_word_t rd_q[$];

  initial begin
    {addr_o, rw_o, susp_o, ilv_o, odis_o, sel_o, adv_o} = '0;
    {wd1, wd2, wv, last, we1, we2, wen, wb} = '0;
    be_n_o = BE_OFF_N;
  end

  // released bus shows the inverse of its last level
  assign bus_o = wen ? wv : (rd_oe_i ? rd_data_i : ~last);

  always @(posedge ref_clk_i) begin
    if (rd_oe_i && susp_o == 2'h0) begin
      rd_q.push_back(rd_data_i);
    end
    if (rd_oe_i || wen) begin
      last <= bus_o;
    end
  end

  task automatic cyc(input logic adv, input logic rw, input pbs_addr_t a,
                     input logic [NBYTE-1:0] be, input pbs_word_t d,
                     input logic [2:0] sel, input logic [1:0] susp);
    @(negedge ref_clk_i);
    adv_o = adv;
    rw_o = rw;
    addr_o = a;
    be_n_o = be;
    sel_o = sel;
    susp_o = susp;
    if (susp == 2'h0) begin
      wb = adv ? wb : (sel == 3'h2 && !rw);
      wen = we2;
      wv = wd2;
      we2 = we1;
      wd2 = wd1;
      we1 = wb;
      wd1 = d;
    end
  endtask
endmodule

// [tb/pbs_port_test.sv]
// bench of the pipelined burst memory port
// assumes pbs_host drives every input of the port except clock and reset
`timescale 1ns/1ps
module pbs_port_test import pbs_pkg::*;;
  localparam logic [2:0] SEL = 3'h2;
  localparam pbs_addr_t  A   = 19'h5a3c1;
  localparam pbs_word_t  W1  = 36'h9a5c3e71d;
  logic             ref_clk_i, arst_n_i;
  logic             adv, rw, ilv, odis, oe;
  logic [1:0]       susp;
  logic [2:0]       sel;
  logic [NBYTE-1:0] be_n;
  pbs_addr_t        addr;
  pbs_word_t        rd_d, bus;
  int               error_cnt, compares;

  pbs_host u_pbs_host (
    .ref_clk_i(ref_clk_i), .rd_data_i(rd_d), .rd_oe_i(oe), .addr_o(addr),
    .adv_o(adv), .rw_o(rw), .susp_o(susp), .be_n_o(be_n), .sel_o(sel),
    .ilv_o(ilv), .odis_o(odis), .bus_o(bus));
  pbs_port u_pbs_port (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .address_in_i(addr),
    .advance_or_load_i(adv), .read_write_i(rw), .clock_hold_n_i(susp[0]),
    .byte_write_n_i(be_n), .chip_select_a_n_i(sel[2]),
    .chip_select_high_i(sel[1]), .chip_select_b_n_i(sel[0]),
    .burst_order_select_i(ilv), .output_disable_i(odis),
    .sleep_request_i(susp[1]), .data_bus_i(bus), .data_bus_o(rd_d),
    .data_bus_oe_o(oe));

  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input pbs_word_t got, input pbs_word_t exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input pbs_word_t e[$]);
    check(pbs_word_t'(u_pbs_host.rd_q.size()), pbs_word_t'(e.size()));
    foreach (e[i]) begin
      check(i < u_pbs_host.rd_q.size() ? u_pbs_host.rd_q[i] : 'x, e[i]);
    end
    u_pbs_host.rd_q.delete();
  endtask

  task automatic oe_chk(input logic e, input pbs_word_t d);
    check(pbs_word_t'(oe), pbs_word_t'(e));
    if (e) begin
      check(rd_d, d);
    end
  endtask

  task automatic ld(input logic r, input pbs_addr_t a,
                    input logic [NBYTE-1:0] be, input pbs_word_t d);
    u_pbs_host.cyc(1'b0, r, a, be, d, SEL, 2'h0);
  endtask

  task automatic step(input pbs_word_t d);
    u_pbs_host.cyc(1'b1, 1'b0, '1, 4'h0, d, SEL, 2'h0);
  endtask

  // deselect cycles with a junk address
  task automatic nop(input int n);
    repeat (n) u_pbs_host.cyc(1'b0, 1'b0, '1, 4'h0, '0, 3'h0, 2'h0);
  endtask

  function automatic logic [1:0] lo(input logic [1:0] b, input int n,
                                    input logic i);
    lo = i ? b ^ 2'(n) : b + 2'(n);
  endfunction

  task automatic s_turn();
    ld(1'b0, A, 4'h0, W1);
    ld(1'b1, A, 4'h0, '0);
    ld(1'b0, A + 1, 4'h0, ~W1);
    ld(1'b1, A + 1, 4'h0, '0);
    ld(1'b1, A, 4'h0, '0);
    nop(2);
    oe_chk(1'b1, ~W1);
    nop(4);
    rd_chk({W1, ~W1, W1});
  endtask

  task automatic s_byte();
    pbs_word_t p, m;
    p = 36'h3c96a5f0e;
    m = {9'h0, 9'h1ff, 9'h0, 9'h1ff};
    ld(1'b0, A + 2, 4'h0, W1);
    ld(1'b0, A + 2, 4'ha, p);
    ld(1'b1, A + 2, 4'h0, p);
    ld(1'b1, A + 2, 4'h0, p);
    nop(4);
    rd_chk({(p & m) | (W1 & ~m), (p & m) | (W1 & ~m)});
  endtask

  task automatic s_burst(input logic il);
    pbs_word_t ex[4];
    pbs_word_t q[$];
    pbs_addr_t c;
    c = {il, 16'hbeef, 2'h2};
    u_pbs_host.ilv_o = il;
    ld(1'b0, c, 4'h0, W1);
    for (int n = 1; n < 4; n++) step(W1 + n);
    ld(1'b1, c - 1, 4'h0, '0);
    for (int n = 1; n < 4; n++) step('0);
    nop(4);
    for (int n = 0; n < 4; n++) ex[lo(2'h2, n, il)] = W1 + n;
    for (int n = 0; n < 4; n++) q.push_back(ex[lo(2'h1, n, il)]);
    rd_chk(q);
  endtask

  task automatic s_hold();
    ld(1'b1, A, 4'h0, '0);
    u_pbs_host.cyc(1'b0, 1'b0, A, 4'h0, ~W1, SEL, 2'h1);
    nop(2);
    oe_chk(1'b0, '0);
    u_pbs_host.cyc(1'b0, 1'b0, A, 4'h0, ~W1, SEL, 2'h1);
    oe_chk(1'b1, W1);
    nop(1);
    oe_chk(1'b1, W1);
    nop(1);
    oe_chk(1'b0, '0);
    ld(1'b1, A, 4'h0, '0);
    nop(4);
    rd_chk({W1, W1});
  endtask

  task automatic s_desel();
    for (int k = 0; k < 3; k++) begin
      ld(1'b1, A, 4'h0, '0);
      u_pbs_host.cyc(1'b0, 1'b0, A, 4'h0, ~W1, SEL ^ 3'(1 << k), 2'h0);
      step('0);
      step('0);
      ld(1'b1, A, 4'h0, '0);
      nop(4);
      rd_chk({W1, W1});
    end
  endtask

  task automatic s_float();
    ld(1'b1, A, 4'h0, '0);
    nop(3);
    u_pbs_host.odis_o = 1'b1;
    #1;
    oe_chk(1'b0, '0);
    u_pbs_host.odis_o = 1'b0;
    #1;
    oe_chk(1'b1, W1);
    ld(1'b1, A, 4'h0, '0);
    repeat (3) u_pbs_host.cyc(1'b0, 1'b0, A, 4'h0, ~W1, SEL, 2'h2);
    ld(1'b1, A, 4'h0, '0);
    nop(4);
    rd_chk({W1, W1, W1});
  endtask

  task automatic report_and_stop();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    error_cnt = 0;
    compares = 0;
    arst_n_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    arst_n_i = 1'b1;
    oe_chk(1'b0, '0);
    check(rd_d, '0);
    s_turn();
    s_byte();
    s_burst(1'b0);
    nop(1);
    s_burst(1'b1);
    s_hold();
    s_desel();
    s_float();
    report_and_stop();
  end
endmodule
